// file: half_bridge_fault_supervisor.sv
/*
 Fault supervision and flag latching for a ten-channel half-bridge driver,
 with an AHB-Lite register slave for commands, control and status.
 Assumes all sense and supply indications are synchronous to mclk and
 already filtered by the analog comparators.
*/
// Contract
// - Persistent overcurrent for the delay sets the channel flag and disables it.
// - Status reset clears overcurrent flags and re-enables outputs in selected group.
// - Thermal warning follows the pre-warning indication and clears by itself.
// - Thermal shutdown latches channel off, keeps warning, sets status bit 15.
// - Shutdown clears only after temperature is gone and status reset written.
// - Persistent motor supply undervoltage sets supply fail and disables all outputs.
// - Outputs resume after undervoltage ends without a status reset.
// - Logic supply undervoltage ignores bus, outputs off, registers cleared.
// - On logic supply recovery, status reset works again.
// - Overvoltage with lock enabled turns all outputs off and sets supply fail.
// - Overvoltage fault does not latch; outputs and flags recover automatically.
// - After unlatched faults outputs follow the current command at once.
// - Unlatched status bits return to no-fault once the cause disappears.
// - Underload persisting for the open-load delay sets the channel flag.
// - With shutdown enabled, open load disables output until status reset.
// - Enable low turns all outputs off and resets all registers.
module half_bridge_fault_supervisor #(
    parameter int CNT_W = 16,
    parameter int OC_CYCLES = half_bridge_fault_pkg::OC_CYCLES,
    parameter int UV_CYCLES = half_bridge_fault_pkg::UV_CYCLES,
    parameter int OL_CYCLES = half_bridge_fault_pkg::OL_CYCLES
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic enablePin,
    input wire logic vccUnder,
    input wire logic vsUnder,
    input wire logic vsOver,
    input wire half_bridge_fault_pkg::chanSense_s sense,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic [half_bridge_fault_pkg::NCH-1:0] hsDrive,
    output logic [half_bridge_fault_pkg::NCH-1:0] lsDrive
);

    localparam int N = half_bridge_fault_pkg::NCH;
    localparam logic [CNT_W-1:0] OC_LAST = CNT_W'(OC_CYCLES - 1);
    localparam logic [CNT_W-1:0] UV_LAST = CNT_W'(UV_CYCLES - 1);
    localparam logic [CNT_W-1:0] OL_LAST = CNT_W'(OL_CYCLES - 1);

    // Sleep and logic undervoltage act as one synchronous clear
    logic clr;
    logic take;
    logic wrPend_reg;
    logic [7:0] wrAddr_reg;
    logic [31:0] hrdata_reg;
    logic [31:0] cmd_reg;
    logic [31:0] ctrl_reg;
    logic srrPulse_reg;
    logic [N-1:0] srrMask;
    logic [N-1:0] groupMask;
    logic [N-1:0] ocFlag_reg;
    logic [N-1:0] tsdFlag_reg;
    logic [N-1:0] olFlag_reg;
    logic [N-1:0] olOff_reg;
    logic [N-1:0] chanOn;
    logic [CNT_W-1:0] olCnt_reg;
    logic [CNT_W-1:0] uvCnt_reg;
    logic uvFault_reg;
    logic ovFault;
    logic supplyFail;
    logic anyUnderLoad;
    logic olHit;
    logic uvHit;
    logic [31:0] statusWord;
    logic [31:0] readValue;
    logic [N-1:0] hsDrive_reg;
    logic [N-1:0] lsDrive_reg;

    assign clr = !enablePin || vccUnder;

    // Zero-wait slave; every access completes OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_reg;
    assign take = hsel && htrans[1] && hready;

    // Address phase of a write is held for its data phase
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            wrPend_reg <= 1'b0;
            wrAddr_reg <= 8'h00;
        end
        else
        begin
            wrPend_reg <= take && hwrite && !clr;
            wrAddr_reg <= haddr[7:0];
        end
    end

    // Output commands
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            cmd_reg <= half_bridge_fault_pkg::CMD_RESET;
        else if (clr)
            cmd_reg <= half_bridge_fault_pkg::CMD_RESET;
        else if (wrPend_reg && wrAddr_reg == half_bridge_fault_pkg::CMD_OFS)
            cmd_reg <= {12'h000, hwdata[half_bridge_fault_pkg::CMD_W-1:0]};
    end

    // Control settings; the status reset bit is not stored
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            ctrl_reg <= half_bridge_fault_pkg::CTRL_RESET;
        else if (clr)
            ctrl_reg <= half_bridge_fault_pkg::CTRL_RESET;
        else if (wrPend_reg && wrAddr_reg == half_bridge_fault_pkg::CTRL_OFS)
            ctrl_reg <= {29'h0000_0000, hwdata[half_bridge_fault_pkg::CTRL_W-1:0]};
    end

    // Status reset fires once, after the write that carries it completes
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            srrPulse_reg <= 1'b0;
        else
            srrPulse_reg <= !clr && wrPend_reg
                && wrAddr_reg == half_bridge_fault_pkg::CTRL_OFS
                && hwdata[half_bridge_fault_pkg::SRR_BIT];
    end

    // Group taken from the select in force when the pulse fires
    assign groupMask = ctrl_reg[half_bridge_fault_pkg::GROUP_SEL_BIT]
        ? half_bridge_fault_pkg::GROUP1_MASK
        : half_bridge_fault_pkg::GROUP0_MASK;
    assign srrMask = srrPulse_reg ? groupMask : '0;

    // Per-channel overcurrent timers and latched flags
    genvar i;
    generate
        for (i = 0; i < N; i++)
        begin : g_chan
            logic [CNT_W-1:0] ocCnt_reg;
            logic ocHit;

            // Timer restarts after a clear, so a lasting short re-trips
            assign ocHit = sense.overCurrent[i] && !ocFlag_reg[i]
                && ocCnt_reg == OC_LAST;

            always_ff @(posedge mclk or posedge rst)
            begin
                if (rst)
                    ocCnt_reg <= '0;
                else if (clr || !sense.overCurrent[i] || ocFlag_reg[i] || srrMask[i])
                    ocCnt_reg <= '0;
                else
                    ocCnt_reg <= ocCnt_reg + 1'b1;
            end

            always_ff @(posedge mclk or posedge rst)
            begin
                if (rst)
                    ocFlag_reg[i] <= 1'b0;
                else if (clr)
                    ocFlag_reg[i] <= 1'b0;
                else if (ocHit)
                    ocFlag_reg[i] <= 1'b1;
                else if (srrMask[i])
                    ocFlag_reg[i] <= 1'b0;
            end

            // A clear while still hot is overridden: set wins
            always_ff @(posedge mclk or posedge rst)
            begin
                if (rst)
                    tsdFlag_reg[i] <= 1'b0;
                else if (clr)
                    tsdFlag_reg[i] <= 1'b0;
                else if (sense.tempShutdown[i])
                    tsdFlag_reg[i] <= 1'b1;
                else if (srrMask[i])
                    tsdFlag_reg[i] <= 1'b0;
            end

            always_ff @(posedge mclk or posedge rst)
            begin
                if (rst)
                    olFlag_reg[i] <= 1'b0;
                else if (clr)
                    olFlag_reg[i] <= 1'b0;
                else if (olHit && sense.underLoad[i])
                    olFlag_reg[i] <= 1'b1;
                else if (srrMask[i])
                    olFlag_reg[i] <= 1'b0;
            end

            always_ff @(posedge mclk or posedge rst)
            begin
                if (rst)
                    olOff_reg[i] <= 1'b0;
                else if (clr)
                    olOff_reg[i] <= 1'b0;
                else if (olHit && sense.underLoad[i]
                    && ctrl_reg[half_bridge_fault_pkg::OPENLOAD_SHUTDOWN_ENABLE_BIT])
                    olOff_reg[i] <= 1'b1;
                else if (srrMask[i])
                    olOff_reg[i] <= 1'b0;
            end
        end
    endgenerate

    // One shared underload timer; a late channel only waits the remainder
    assign anyUnderLoad = |sense.underLoad;
    assign olHit = anyUnderLoad && olCnt_reg == OL_LAST;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            olCnt_reg <= '0;
        else if (clr || !anyUnderLoad || olHit)
            olCnt_reg <= '0;
        else
            olCnt_reg <= olCnt_reg + 1'b1;
    end

    // Motor supply undervoltage: persistence timer, unlatched fault
    assign uvHit = vsUnder && !uvFault_reg && uvCnt_reg == UV_LAST;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            uvCnt_reg <= '0;
        else if (clr || !vsUnder || uvFault_reg)
            uvCnt_reg <= '0;
        else
            uvCnt_reg <= uvCnt_reg + 1'b1;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            uvFault_reg <= 1'b0;
        else if (clr || !vsUnder)
            uvFault_reg <= 1'b0;
        else if (uvHit)
            uvFault_reg <= 1'b1;
    end

    // Overvoltage ignores the group select and never latches
    assign ovFault = vsOver && ctrl_reg[half_bridge_fault_pkg::OVERVOLTAGE_LOCK_ENABLE_EN_BIT];
    assign supplyFail = uvFault_reg || ovFault;

    // Latched faults gate per channel, supply faults gate all
    assign chanOn = ~(ocFlag_reg | tsdFlag_reg | olOff_reg)
        & {N{!supplyFail}};

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            hsDrive_reg <= '0;
            lsDrive_reg <= '0;
        end
        else if (clr)
        begin
            hsDrive_reg <= '0;
            lsDrive_reg <= '0;
        end
        else
        begin
            hsDrive_reg <= cmd_reg[half_bridge_fault_pkg::CMD_HS_LSB +: N] & chanOn;
            lsDrive_reg <= cmd_reg[half_bridge_fault_pkg::CMD_LS_LSB +: N] & chanOn;
        end
    end

    assign hsDrive = hsDrive_reg;
    assign lsDrive = lsDrive_reg;

    // Warning stays up while any channel is latched hot
    always_comb
    begin
        statusWord = '0;
        statusWord[half_bridge_fault_pkg::ST_TSD_BIT] = |tsdFlag_reg;
        statusWord[half_bridge_fault_pkg::ST_TW_BIT] =
            |(sense.tempWarn | tsdFlag_reg);
        statusWord[half_bridge_fault_pkg::ST_PSF_BIT] = supplyFail;
        statusWord[half_bridge_fault_pkg::ST_UV_BIT] = uvFault_reg;
        statusWord[half_bridge_fault_pkg::ST_OV_BIT] = ovFault;
    end

    always_comb
    begin
        readValue = '0;
        unique case (haddr[7:0])
            half_bridge_fault_pkg::CMD_OFS: readValue = cmd_reg;
            half_bridge_fault_pkg::CTRL_OFS: readValue = ctrl_reg;
            half_bridge_fault_pkg::STATUS_OFS: readValue = statusWord;
            half_bridge_fault_pkg::OCFLAG_OFS: readValue = {22'h00_0000, ocFlag_reg};
            half_bridge_fault_pkg::OLFLAG_OFS: readValue = {22'h00_0000, olFlag_reg};
            half_bridge_fault_pkg::TSDFLAG_OFS: readValue = {22'h00_0000, tsdFlag_reg};
            half_bridge_fault_pkg::DRIVE_OFS: readValue = {12'h000, lsDrive_reg, hsDrive_reg};
            default: readValue = '0;
        endcase
    end

    // Read data is registered for the data phase; bus is dead in sleep and logic undervoltage
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            hrdata_reg <= '0;
        else if (take && !hwrite && !clr)
            hrdata_reg <= readValue;
        else
            hrdata_reg <= '0;
    end

endmodule : half_bridge_fault_supervisor

// file: half_bridge_fault_pkg.sv
/*
 Shared constants and carrier types for the half-bridge fault supervisor.
 Assumes a 10 MHz logic clock and an AHB-Lite register bus of 32-bit words.
*/
package half_bridge_fault_pkg;

    localparam int NCH = 10;
    localparam int CLK_PERIOD_NS = 100;

    // Persistence delays, in ns
    localparam int OC_DELAY_NS = 20000;
    localparam int UV_DELAY_NS = 40000;
    localparam int OL_DELAY_NS = 200000;

    // Least times round up to whole cycles
    localparam int OC_CYCLES = (OC_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int UV_CYCLES = (UV_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OL_CYCLES = (OL_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Register byte offsets
    localparam logic [7:0] CMD_OFS = 8'h00;
    localparam logic [7:0] CTRL_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    localparam logic [7:0] OCFLAG_OFS = 8'h0c;
    localparam logic [7:0] OLFLAG_OFS = 8'h10;
    localparam logic [7:0] TSDFLAG_OFS = 8'h14;
    localparam logic [7:0] DRIVE_OFS = 8'h18;

    // Command word: high-side commands low, low-side commands above
    localparam int CMD_HS_LSB = 0;
    localparam int CMD_LS_LSB = 10;
    localparam int CMD_W = 20;

    // Control word fields
    localparam int GROUP_SEL_BIT = 0;
    localparam int OVERVOLTAGE_LOCK_ENABLE_EN_BIT = 1;
    localparam int OPENLOAD_SHUTDOWN_ENABLE_BIT = 2;
    localparam int SRR_BIT = 8;
    localparam int CTRL_W = 3;

    // Status word fields
    localparam int ST_TSD_BIT = 15;
    localparam int ST_TW_BIT = 14;
    localparam int ST_PSF_BIT = 13;
    localparam int ST_UV_BIT = 12;
    localparam int ST_OV_BIT = 11;

    // Channel groups: select 0 covers bridges 1..6, select 1 bridges 7..10
    localparam logic [NCH-1:0] GROUP0_MASK = 10'h03f;
    localparam logic [NCH-1:0] GROUP1_MASK = 10'h3c0;

    localparam logic [31:0] CMD_RESET = 32'h0000_0000;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    typedef struct packed {
        logic [NCH-1:0] overCurrent;
        logic [NCH-1:0] tempWarn;
        logic [NCH-1:0] tempShutdown;
        logic [NCH-1:0] underLoad;
    } chanSense_s;

endpackage : half_bridge_fault_pkg

// file: half_bridge_fault_monitor.sv
/*
 Port checker for the half-bridge fault supervisor, bound to every instance.
 Assumes one clock, mclk, and the asynchronous active-high reset rst.
*/
module half_bridge_fault_monitor #(
    parameter int OC_CYCLES = 4,
    parameter int UV_CYCLES = 4
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic enablePin,
    input wire logic vccUnder,
    input wire logic vsUnder,
    input wire half_bridge_fault_pkg::chanSense_s sense,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic [half_bridge_fault_pkg::NCH-1:0] hsDrive,
    input wire logic [half_bridge_fault_pkg::NCH-1:0] lsDrive
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] ocRun;
    logic [15:0] uvRun;
    wire drvOff = (hsDrive | lsDrive) == '0;
    // Run lengths of the fault causes, as the design should count them
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            ocRun <= 16'h0000;
            uvRun <= 16'h0000;
        end
        else
        begin
            ocRun <= sense.overCurrent[0] ? ocRun + 16'h0001 : 16'h0000;
            uvRun <= vsUnder ? uvRun + 16'h0001 : 16'h0000;
        end
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    sequence sleepExit;
        $rose(enablePin) && !vccUnder;
    endsequence
    sequence tsdSeen;
        sense.tempShutdown[0] ##1 1'b1;
    endsequence
    a_oc_trip_off: assert property (ocRun == OC_CYCLES |=> !hsDrive[0] && !lsDrive[0])
        else $error("overcurrent channel still driven");
    a_uv_all_off: assert property (uvRun == UV_CYCLES |=> drvOff)
        else $error("undervoltage left outputs on");
    a_tsd_latch_off: assert property (tsdSeen |=> !hsDrive[0] && !lsDrive[0])
        else $error("thermal shutdown channel still driven");
    a_sleep_off: assert property (!enablePin |=> drvOff)
        else $error("sleep left outputs on");
    a_vcc_clear: assert property (vccUnder |=> drvOff && hrdata == 32'h0)
        else $error("logic undervoltage left outputs or read data");
    a_wake_quiet: assert property (sleepExit |=> drvOff)
        else $error("outputs on straight after wake");
    a_read_idle: assert property (!(hsel && htrans[1] && hready && !hwrite) |=> hrdata == 32'h0)
        else $error("read data outside a read data phase");
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus response not ready okay");
endmodule : half_bridge_fault_monitor

bind half_bridge_fault_supervisor half_bridge_fault_monitor #(
    .OC_CYCLES(OC_CYCLES),
    .UV_CYCLES(UV_CYCLES)
) i_half_bridge_fault_monitor (
    .mclk(mclk), .rst(rst), .enablePin(enablePin), .vccUnder(vccUnder),
    .vsUnder(vsUnder), .sense(sense), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .hsDrive(hsDrive), .lsDrive(lsDrive)
);

// file: host_ahb_model.sv
/*
 Host side of the register bus: an AHB-Lite master doing single word transfers.
 Assumes xfer is entered right after a rising edge of mclk.
*/
module host_ahb_model (
    input wire logic mclk,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    output logic timedOut
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        {hsel, htrans, hwrite, haddr, hwdata, timedOut} = '0;
        hsize = 3'b010;
    end
    // Bounded so a stuck slave ends the run instead of hanging it
    task automatic waitReady();
        int n;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1)
        begin
            timedOut = 1'b1;
        end
    endtask : waitReady
    task automatic xfer(input logic wr, input logic [7:0] ofs, input logic [31:0] wd,
                        output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {24'h000000, ofs};
        waitReady();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        waitReady();
        rd = hrdata;
        hwdata <= ~wd;
    endtask : xfer
endmodule : host_ahb_model

// file: tb.sv
/*
 Register-level testbench for the half-bridge fault supervisor.
 Assumes short persistence delays set here: 4, 4 and 8 cycles.
*/
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] O_CMD = half_bridge_fault_pkg::CMD_OFS;
    localparam logic [7:0] O_CTL = half_bridge_fault_pkg::CTRL_OFS;
    localparam logic [7:0] O_ST = half_bridge_fault_pkg::STATUS_OFS;
    localparam logic [7:0] O_OC = half_bridge_fault_pkg::OCFLAG_OFS;
    localparam logic [7:0] O_OL = half_bridge_fault_pkg::OLFLAG_OFS;
    localparam logic [7:0] O_TS = half_bridge_fault_pkg::TSDFLAG_OFS;
    logic mclk, rst, enablePin, vccUnder, vsUnder, vsOver, hsel, hwrite, timedOut;
    logic hreadyout, hresp;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rdv;
    logic [9:0] hsDrive, lsDrive;
    half_bridge_fault_pkg::chanSense_s sense;
    int errTotal = 0;
    int samplesChecked = 0;
    half_bridge_fault_supervisor #(.OC_CYCLES(4), .UV_CYCLES(4), .OL_CYCLES(8))
    i_half_bridge_fault_supervisor (
        .mclk(mclk), .rst(rst), .enablePin(enablePin), .vccUnder(vccUnder),
        .vsUnder(vsUnder), .vsOver(vsOver), .sense(sense), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .hsDrive(hsDrive), .lsDrive(lsDrive));
    host_ahb_model i_host_ahb_model (
        .mclk(mclk), .hreadyout(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .timedOut(timedOut));
    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    task automatic finishTest();
        $display("compared %0d mismatched %0d", samplesChecked, errTotal);
        if (errTotal == 0 && samplesChecked > 0)
        begin
            $display("ALL CHECKS OK");
        end
        else
        begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : finishTest
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp)
        begin
            errTotal++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask : cyc
    task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
        i_host_ahb_model.xfer(1'b1, ofs, d, rdv);
    endtask : wr
    task automatic rdChk(input logic [7:0] ofs, input logic [31:0] exp);
        i_host_ahb_model.xfer(1'b0, ofs, 32'h00000000, rdv);
        chk(rdv, exp);
    endtask : rdChk
    task automatic drvChk(input logic [31:0] exp);
        chk({12'h000, lsDrive, hsDrive}, exp);
    endtask : drvChk
    always @(posedge timedOut)
    begin
        errTotal++;
        finishTest();
    end
    initial
    begin
        {rst, enablePin} = 2'b11;
        {vccUnder, vsUnder, vsOver} = 3'b000;
        sense = '0;
        cyc(10);
        rst <= 1'b0;
        cyc(1);
        rdChk(O_CMD, 32'h0);
        rdChk(8'h1c, 32'h0);
        wr(O_CMD, 32'h003ff);
        cyc(2);
        drvChk(32'h003ff);
        sense.overCurrent <= 10'h081;
        cyc(6);
        sense.overCurrent <= 10'h000;
        rdChk(O_OC, 32'h081);
        drvChk(32'h0037e);
        wr(O_CTL, 32'h100);
        cyc(3);
        rdChk(O_OC, 32'h080);
        drvChk(32'h0037f);
        wr(O_CTL, 32'h101);
        cyc(3);
        rdChk(O_OC, 32'h0);
        sense.tempWarn <= 10'h004;
        cyc(2);
        rdChk(O_ST, 32'h4000);
        sense.tempWarn <= 10'h000;
        cyc(2);
        rdChk(O_ST, 32'h0);
        sense.tempShutdown <= 10'h001;
        cyc(2);
        rdChk(O_ST, 32'hc000);
        drvChk(32'h003fe);
        wr(O_CTL, 32'h100);
        cyc(3);
        rdChk(O_TS, 32'h001);
        sense.tempShutdown <= 10'h000;
        wr(O_CTL, 32'h101);
        cyc(3);
        rdChk(O_TS, 32'h001);
        wr(O_CTL, 32'h100);
        cyc(3);
        rdChk(O_ST, 32'h0);
        drvChk(32'h003ff);
        vsUnder <= 1'b1;
        cyc(6);
        drvChk(32'h0);
        rdChk(O_ST, 32'h3000);
        wr(O_CMD, 32'h00c00);
        vsUnder <= 1'b0;
        cyc(3);
        drvChk(32'h00c00);
        rdChk(O_ST, 32'h0);
        wr(O_CMD, 32'h003ff);
        vsOver <= 1'b1;
        cyc(2);
        drvChk(32'h003ff);
        wr(O_CTL, 32'h003);
        cyc(2);
        drvChk(32'h0);
        rdChk(O_ST, 32'h2800);
        vsOver <= 1'b0;
        cyc(2);
        drvChk(32'h003ff);
        rdChk(O_ST, 32'h0);
        wr(O_CTL, 32'h004);
        sense.underLoad <= 10'h002;
        cyc(10);
        sense.underLoad <= 10'h000;
        rdChk(O_OL, 32'h002);
        drvChk(32'h003fd);
        wr(O_CTL, 32'h104);
        cyc(3);
        rdChk(O_OL, 32'h0);
        drvChk(32'h003ff);
        // Cause left on across the reset must trip again after a full delay
        sense.overCurrent <= 10'h001;
        cyc(6);
        wr(O_CTL, 32'h100);
        // Released first, then held on for the whole restarted delay
        cyc(5);
        drvChk(32'h003ff);
        cyc(3);
        drvChk(32'h003fe);
        sense.overCurrent <= 10'h000;
        vccUnder <= 1'b1;
        wr(O_CMD, 32'h003ff);
        rdChk(O_ST, 32'h0);
        drvChk(32'h0);
        vccUnder <= 1'b0;
        cyc(1);
        rdChk(O_CMD, 32'h0);
        rdChk(O_OC, 32'h0);
        // Both switches of bridge 1 commanded, so the latch must drop each
        wr(O_CMD, 32'h00401);
        sense.tempShutdown <= 10'h001;
        cyc(2);
        sense.tempShutdown <= 10'h000;
        wr(O_CTL, 32'h100);
        drvChk(32'h0);
        cyc(3);
        rdChk(O_TS, 32'h0);
        drvChk(32'h00401);
        wr(O_CMD, 32'h003ff);
        enablePin <= 1'b0;
        cyc(2);
        drvChk(32'h0);
        enablePin <= 1'b1;
        cyc(1);
        rdChk(O_CMD, 32'h0);
        finishTest();
    end
endmodule : tb
